/* File: core/fpcs_pkg.sv */
// Purpose: Shared constants and types for the programming command engine.
// Assumes: Byte-wide flash array of 4096 bytes in 16 blocks.
// Notes:   Security bit positions are shared by the engine and its checks.

package fpcs_pkg;

  // ==========================================================================
  // Sizes
  localparam int ADDR_W = 12;
  localparam int BLK_W = 4;
  localparam int DATA_W = 8;
  localparam int CKS_W = 16;
  localparam int SEC_W = 3;
  localparam int BLK_SHIFT = ADDR_W - BLK_W;

  // ==========================================================================
  // Values
  localparam logic [ADDR_W-1:0] ADDR_FIRST = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 12'hfff;
  localparam logic [BLK_SHIFT-1:0] BLK_BASE_LO = 8'h00;
  localparam logic [DATA_W-1:0] BLANK_BYTE = 8'hff;
  localparam logic [CKS_W-1:0] CKS_RST = 16'h0000;
  localparam logic [SEC_W-1:0] SEC_RST = 3'h0;

  // ==========================================================================
  // Security bit positions
  localparam int SEC_CHIP = 0;
  localparam int SEC_BLK = 1;
  localparam int SEC_WR = 2;

  // ==========================================================================
  // Commands from the programmer
  typedef enum logic [3:0] {
    CMD_COMM = 4'h0,
    CMD_CHIP_ERASE = 4'h1,
    CMD_BLOCK_ERASE = 4'h2,
    CMD_WRITE = 4'h3,
    CMD_DATA = 4'h4,
    CMD_CHECKSUM = 4'h5,
    CMD_BLANK = 4'h6,
    CMD_SECURITY = 4'h7
  } fpcs_cmd_t;

  // ==========================================================================
  // Flash array operations
  typedef enum logic [1:0] {
    FOP_ERASE_ALL = 2'h0,
    FOP_ERASE_BLK = 2'h1,
    FOP_PROG = 2'h2,
    FOP_READ = 2'h3
  } fpcs_fop_t;

  // ==========================================================================
  // Engine states
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_EXEC = 2'h1,
    ST_VRFY = 2'h2
  } fpcs_state_t;

endpackage

/* File: core/fpcs_sync.sv */
// Purpose: Two-stage synchroniser for a level from outside the clock domain.
// Assumes: The input is a slow level.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ns
`default_nettype none

module fpcs_sync
  import fpcs_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic async_in,
  output logic sync_out
);

  // ==========================================================================
  // Stages
  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule
`default_nettype wire

/* File: core/fpcs_engine.sv */
// Purpose: Programming command engine with security prohibitions.
// Assumes: Flash array answers each fl_req pulse with one fl_done pulse.
// Notes:   Nonvolatile security bits are modelled by flip-flops.
//
// Function
// - Enter programming mode on communication command
// - Chip erase erases all unless prohibited
// - Block erase erases only named block
// - Write programs range then verifies contents
// - Checksum computed over requested range
// - Blank check scans whole array, reports
// - Every command or data item gets ACK/NAK
// - New security applies from next mode entry
// - Chip prohibit blocks all erases, never clears
// - Chip prohibit: write allowed, changes fail
// - Block prohibit refuses block erase, chip clears
// - Write prohibit refuses write, block erase
// - Delivered state has all prohibitions clear
// - Only programmer path can set security
// - Prohibitions independent, effects combine
// - Self programming ignores security
`timescale 1ns/1ns
`default_nettype none

module fpcs_engine
  import fpcs_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic prog_conn_pin,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [3:0] cmd_code,
  input wire logic [BLK_W-1:0] cmd_block,
  input wire logic [ADDR_W-1:0] cmd_start,
  input wire logic [ADDR_W-1:0] cmd_end,
  input wire logic [DATA_W-1:0] cmd_data,
  input wire logic [SEC_W-1:0] cmd_sec,
  output logic resp_valid,
  output logic resp_ack,
  output logic [CKS_W-1:0] resp_data,
  output logic prog_mode,
  output logic [SEC_W-1:0] sec_active,
  input wire logic sp_valid,
  output logic sp_ready,
  input wire logic sp_erase,
  input wire logic [BLK_W-1:0] sp_block,
  input wire logic [ADDR_W-1:0] sp_addr,
  input wire logic [DATA_W-1:0] sp_data,
  output logic sp_done,
  output logic sp_ok,
  output logic fl_req,
  output logic [1:0] fl_op,
  output logic [ADDR_W-1:0] fl_addr,
  output logic [DATA_W-1:0] fl_wdata,
  input wire logic [DATA_W-1:0] fl_rdata,
  input wire logic fl_done
);

  // ==========================================================================
  // State
  fpcs_state_t state_ff;
  logic conn_sync;
  logic prog_mode_ff;
  logic [SEC_W-1:0] nv_sec_ff;
  logic [SEC_W-1:0] act_sec_ff;
  logic src_sp_ff;
  logic wr_open_ff;
  logic [ADDR_W-1:0] ptr_ff;
  logic [ADDR_W-1:0] end_ff;
  logic [ADDR_W-1:0] scan_end_ff;
  logic [CKS_W-1:0] sum_ff;
  logic blank_ff;
  logic fl_req_ff;
  logic [1:0] fl_op_ff;
  logic [ADDR_W-1:0] fl_addr_ff;
  logic [DATA_W-1:0] fl_wdata_ff;
  logic resp_valid_ff;
  logic resp_ack_ff;
  logic [CKS_W-1:0] resp_data_ff;
  logic sp_done_ff;
  logic sp_ok_ff;
  logic cmd_take;
  logic sp_take;
  logic enter_go;
  logic sec_go;
  logic chip_ok;
  logic [CKS_W-1:0] sum_next;
  logic blank_next;

  fpcs_sync u_conn_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in(prog_conn_pin),
    .sync_out(conn_sync)
  );

  // ==========================================================================
  // Handshake and events
  assign cmd_ready = (state_ff == ST_IDLE);
  assign sp_ready = (state_ff == ST_IDLE) && !prog_mode_ff && !cmd_valid;
  assign cmd_take = cmd_valid && cmd_ready;
  assign sp_take = sp_valid && sp_ready;
  assign enter_go = cmd_take && (cmd_code == CMD_COMM) && conn_sync &&
                    !prog_mode_ff;
  assign sec_go = cmd_take && prog_mode_ff && (cmd_code == CMD_SECURITY);
  assign chip_ok = (state_ff == ST_EXEC) && fl_done && !src_sp_ff &&
                   (fl_op_ff == FOP_ERASE_ALL);
  assign sum_next = sum_ff + {8'h00, fl_rdata};
  assign blank_next = blank_ff && (fl_rdata == BLANK_BYTE);

  // ==========================================================================
  // Programming mode and security
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prog_mode_ff <= 1'b0;
      act_sec_ff <= SEC_RST;
    end else if (enter_go) begin
      prog_mode_ff <= 1'b1;
      act_sec_ff <= nv_sec_ff;
    end else if (!conn_sync) begin
      prog_mode_ff <= 1'b0;
    end
  end

  // Only the programmer command path reaches the stored bits.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nv_sec_ff <= SEC_RST;
    end else if (sec_go) begin
      nv_sec_ff <= nv_sec_ff | cmd_sec;
    end else if (chip_ok && !nv_sec_ff[SEC_CHIP]) begin
      nv_sec_ff[SEC_BLK] <= 1'b0;
      nv_sec_ff[SEC_WR] <= 1'b0;
    end
  end

  // ==========================================================================
  // Command engine
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_IDLE;
      src_sp_ff <= 1'b0;
      wr_open_ff <= 1'b0;
      ptr_ff <= ADDR_FIRST;
      end_ff <= ADDR_FIRST;
      scan_end_ff <= ADDR_FIRST;
      sum_ff <= CKS_RST;
      blank_ff <= 1'b0;
      fl_req_ff <= 1'b0;
      fl_op_ff <= FOP_READ;
      fl_addr_ff <= ADDR_FIRST;
      fl_wdata_ff <= BLANK_BYTE;
      resp_valid_ff <= 1'b0;
      resp_ack_ff <= 1'b0;
      resp_data_ff <= CKS_RST;
      sp_done_ff <= 1'b0;
      sp_ok_ff <= 1'b0;
    end else begin
      fl_req_ff <= 1'b0;
      resp_valid_ff <= 1'b0;
      sp_done_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (cmd_take) begin
            src_sp_ff <= 1'b0;
            resp_data_ff <= CKS_RST;
            resp_ack_ff <= 1'b0;
            resp_valid_ff <= 1'b1;
            if (cmd_code != CMD_DATA) begin
              wr_open_ff <= 1'b0;
            end
            if (cmd_code == CMD_COMM) begin
              resp_ack_ff <= conn_sync;
            end else if (prog_mode_ff) begin
              case (cmd_code)
                CMD_CHIP_ERASE: begin
                  if (!act_sec_ff[SEC_CHIP]) begin
                    resp_valid_ff <= 1'b0;
                    fl_req_ff <= 1'b1;
                    fl_op_ff <= FOP_ERASE_ALL;
                    state_ff <= ST_EXEC;
                  end
                end
                CMD_BLOCK_ERASE: begin
                  if (act_sec_ff == SEC_RST) begin
                    resp_valid_ff <= 1'b0;
                    fl_req_ff <= 1'b1;
                    fl_op_ff <= FOP_ERASE_BLK;
                    fl_addr_ff <= {cmd_block, BLK_BASE_LO};
                    state_ff <= ST_EXEC;
                  end
                end
                CMD_WRITE: begin
                  if (!act_sec_ff[SEC_WR] && cmd_start <= cmd_end) begin
                    resp_ack_ff <= 1'b1;
                    wr_open_ff <= 1'b1;
                    ptr_ff <= cmd_start;
                    end_ff <= cmd_end;
                  end
                end
                CMD_DATA: begin
                  if (wr_open_ff) begin
                    resp_valid_ff <= 1'b0;
                    fl_req_ff <= 1'b1;
                    fl_op_ff <= FOP_PROG;
                    fl_addr_ff <= ptr_ff;
                    fl_wdata_ff <= cmd_data;
                    state_ff <= ST_EXEC;
                  end
                end
                CMD_CHECKSUM: begin
                  if (cmd_start <= cmd_end) begin
                    resp_valid_ff <= 1'b0;
                    fl_req_ff <= 1'b1;
                    fl_op_ff <= FOP_READ;
                    fl_addr_ff <= cmd_start;
                    scan_end_ff <= cmd_end;
                    sum_ff <= CKS_RST;
                    blank_ff <= 1'b1;
                    state_ff <= ST_EXEC;
                  end
                end
                CMD_BLANK: begin
                  resp_valid_ff <= 1'b0;
                  fl_req_ff <= 1'b1;
                  fl_op_ff <= FOP_READ;
                  fl_addr_ff <= ADDR_FIRST;
                  scan_end_ff <= ADDR_LAST;
                  sum_ff <= CKS_RST;
                  blank_ff <= 1'b1;
                  state_ff <= ST_EXEC;
                end
                CMD_SECURITY: begin
                  resp_ack_ff <= 1'b1;
                end
                default: begin
                  resp_ack_ff <= 1'b0;
                end
              endcase
            end
          end else if (sp_take) begin
            src_sp_ff <= 1'b1;
            fl_req_ff <= 1'b1;
            fl_op_ff <= sp_erase ? FOP_ERASE_BLK : FOP_PROG;
            fl_addr_ff <= sp_erase ? {sp_block, BLK_BASE_LO} : sp_addr;
            fl_wdata_ff <= sp_data;
            state_ff <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (fl_done) begin
            if (fl_op_ff == FOP_PROG) begin
              fl_req_ff <= 1'b1;
              fl_op_ff <= FOP_READ;
              state_ff <= ST_VRFY;
            end else if (fl_op_ff == FOP_READ) begin
              sum_ff <= sum_next;
              blank_ff <= blank_next;
              if (fl_addr_ff == scan_end_ff) begin
                resp_valid_ff <= 1'b1;
                resp_ack_ff <= 1'b1;
                resp_data_ff <= (scan_end_ff == ADDR_LAST &&
                                 act_blank_scan(fl_op_ff)) ?
                                {15'h0, blank_next} : sum_next;
                state_ff <= ST_IDLE;
              end else begin
                fl_addr_ff <= fl_addr_ff + 12'h001;
                fl_req_ff <= 1'b1;
              end
            end else begin
              resp_valid_ff <= !src_sp_ff;
              resp_ack_ff <= 1'b1;
              sp_done_ff <= src_sp_ff;
              sp_ok_ff <= 1'b1;
              state_ff <= ST_IDLE;
            end
          end
        end
        ST_VRFY: begin
          if (fl_done) begin
            // A byte that can only be reached by erasing fails here.
            resp_valid_ff <= !src_sp_ff;
            resp_ack_ff <= (fl_rdata == fl_wdata_ff);
            sp_done_ff <= src_sp_ff;
            sp_ok_ff <= (fl_rdata == fl_wdata_ff);
            if (!src_sp_ff) begin
              ptr_ff <= ptr_ff + 12'h001;
              wr_open_ff <= (fl_rdata == fl_wdata_ff) && (ptr_ff != end_ff);
            end
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Blank check and checksum share the scan; only blank marks blank_scan.
  logic blank_scan_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      blank_scan_ff <= 1'b0;
    end else if (cmd_take) begin
      blank_scan_ff <= (cmd_code == CMD_BLANK);
    end
  end

  function automatic logic act_blank_scan(input logic [1:0] op);
    act_blank_scan = (op == FOP_READ) && blank_scan_ff;
  endfunction

  // ==========================================================================
  // Outputs
  assign resp_valid = resp_valid_ff;
  assign resp_ack = resp_ack_ff;
  assign resp_data = resp_data_ff;
  assign prog_mode = prog_mode_ff;
  assign sec_active = act_sec_ff;
  assign sp_done = sp_done_ff;
  assign sp_ok = sp_ok_ff;
  assign fl_req = fl_req_ff;
  assign fl_op = fl_op_ff;
  assign fl_addr = fl_addr_ff;
  assign fl_wdata = fl_wdata_ff;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_mode_entry: assert property (
    enter_go |=> prog_mode && resp_valid && resp_ack)
    else $error("programming mode not entered on communication");

  chk_chip_refused: assert property (
    cmd_take && prog_mode && cmd_code == CMD_CHIP_ERASE &&
    sec_active[SEC_CHIP] |=> resp_valid && !resp_ack && !fl_req)
    else $error("prohibited chip erase not refused");

  chk_blk_refused: assert property (
    cmd_take && prog_mode && cmd_code == CMD_BLOCK_ERASE &&
    sec_active != SEC_RST |=> resp_valid && !resp_ack && !fl_req)
    else $error("prohibited block erase not refused");

  chk_wr_refused: assert property (
    cmd_take && prog_mode && cmd_code == CMD_WRITE && sec_active[SEC_WR]
    |=> resp_valid && !resp_ack && !wr_open_ff && !fl_req)
    else $error("prohibited write header accepted");

  chk_sec_deferred: assert property (
    sec_go |=> $stable(sec_active) [*2])
    else $error("security took effect in current session");

  chk_entry_latch: assert property (
    $rose(prog_mode) |-> sec_active == $past(nv_sec_ff))
    else $error("active security not loaded at entry");

  chk_chip_sticky: assert property (
    nv_sec_ff[SEC_CHIP] |=> nv_sec_ff[SEC_CHIP])
    else $error("chip erase prohibition cleared");

  chk_chip_clears: assert property (
    chip_ok && !nv_sec_ff[SEC_CHIP] && !sec_go
    |=> nv_sec_ff[SEC_WR:SEC_BLK] == 2'h0)
    else $error("chip erase did not clear prohibitions");

  chk_sp_ignores_sec: assert property (
    sp_take |=> fl_req ##1 state_ff != ST_IDLE)
    else $error("self programming request not executed");

  chk_illegal_nak: assert property (
    cmd_take && cmd_code > CMD_SECURITY |=> resp_valid && !resp_ack)
    else $error("illegal command not answered with NAK");

  chk_verify_fail: assert property (
    state_ff == ST_VRFY && fl_done && !src_sp_ff &&
    fl_rdata != fl_wdata |=> resp_valid && !resp_ack && !wr_open_ff)
    else $error("verify mismatch not reported");

endmodule
`default_nettype wire

/* File: test/fpcs_flash_model.sv */
// Purpose: Behavioural flash array facing the command engine.
// Assumes: Programming can only clear bits; erase sets bytes to ff.
// Notes:   Answers after one or three cycles, picked from the request.
`timescale 1ns/1ns
`default_nettype none

module fpcs_flash_model
  import fpcs_pkg::*;
(
  input wire logic clk,
  input wire logic fl_req,
  input wire logic [1:0] fl_op,
  input wire logic [ADDR_W-1:0] fl_addr,
  input wire logic [DATA_W-1:0] fl_wdata,
  output logic [DATA_W-1:0] fl_rdata,
  output logic fl_done
);
  // ==========================================================================
  // Array
  logic [DATA_W-1:0] mem [0:4095];
  logic [ADDR_W-1:0] addr_ff;
  logic [1:0] cnt_ff;

  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
    cnt_ff = 2'h0;
    fl_done = 1'b0;
    fl_rdata = 8'h00;
  end

  // Read data toggles outside a completion so a stale value never matches.
  always @(posedge clk) begin
    fl_done <= 1'b0;
    fl_rdata <= ~fl_rdata;
    if (fl_req) begin
      addr_ff <= fl_addr;
      cnt_ff <= {fl_addr[1] ^ fl_op[0], 1'b1};
      for (int i = 0; i < 4096 && !fl_op[1]; i++) begin
        if (fl_op == FOP_ERASE_ALL) mem[i] = BLANK_BYTE;
        if (fl_op == FOP_ERASE_BLK && i[11:8] == fl_addr[11:8]) begin
          mem[i] = BLANK_BYTE;
        end
      end
      if (fl_op == FOP_PROG) mem[fl_addr] = mem[fl_addr] & fl_wdata;
    end else if (cnt_ff != 2'h0) begin
      cnt_ff <= cnt_ff - 2'h1;
      if (cnt_ff == 2'h1) begin
        fl_done <= 1'b1;
        fl_rdata <= mem[addr_ff];
      end
    end
  end
endmodule

`default_nettype wire

/* File: test/fpcs_engine_bench.sv */
// Purpose: Self-checking bench for the programming command engine.
// Assumes: Flash model starts with all bytes zero.
// Notes:   A mirror of the array gives the expected checksum, blank and verify answers.
`timescale 1ns/1ns
`default_nettype none

module fpcs_engine_bench
  import fpcs_pkg::*;
;
  // ==========================================================================
  // Signals
  logic clk, arst_n, prog_conn_pin, cmd_valid, cmd_ready;
  logic resp_valid, resp_ack, prog_mode, sp_valid, sp_ready;
  logic sp_erase, sp_done, sp_ok, fl_req, fl_done;
  logic [3:0] cmd_code, cmd_block, sp_block;
  logic [11:0] cmd_start, cmd_end, sp_addr, fl_addr;
  logic [7:0] cmd_data, sp_data, fl_wdata, fl_rdata;
  logic [2:0] cmd_sec, sec_active, st, act;
  logic [15:0] resp_data;
  logic [1:0] fl_op;
  logic [7:0] mem_r [0:4095];
  logic [31:0] x;
  int fails = 0;
  int compares = 0;
  int cyc = 0;

  fpcs_engine dut (.clk, .arst_n, .prog_conn_pin, .cmd_valid, .cmd_ready,
    .cmd_code, .cmd_block, .cmd_start, .cmd_end, .cmd_data, .cmd_sec,
    .resp_valid, .resp_ack, .resp_data, .prog_mode, .sec_active,
    .sp_valid, .sp_ready, .sp_erase, .sp_block, .sp_addr, .sp_data,
    .sp_done, .sp_ok, .fl_req, .fl_op, .fl_addr, .fl_wdata, .fl_rdata,
    .fl_done);

  fpcs_flash_model flash (.clk, .fl_req, .fl_op, .fl_addr, .fl_wdata,
    .fl_rdata, .fl_done);

  // ==========================================================================
  // Helpers
  task automatic results();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic void step();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
  endfunction

  function automatic logic [15:0] cks(input logic [11:0] s, e);
    logic [15:0] t;
    t = 16'h0000;
    for (int i = s; i <= e; i++) t = t + {8'h00, mem_r[i]};
    return t;
  endfunction

  function automatic logic blank();
    blank = 1'b1;
    for (int i = 0; i < 4096; i++) if (mem_r[i] !== 8'hff) blank = 1'b0;
  endfunction

  // Bit 4 set erases the whole mirror, else only block b[3:0].
  task automatic ers(input logic [4:0] b);
    for (int i = 0; i < 4096; i++) if (b[4] || i[11:8] == b[3:0]) begin
      mem_r[i] = 8'hff;
    end
  endtask

  task automatic cmd(input logic [3:0] c, input logic [11:0] s, e,
    input logic [7:0] d, input logic xa, input logic [15:0] xd);
    int n;
    @(negedge clk);
    cmd_valid = 1'b1;
    {cmd_code, cmd_block, cmd_start, cmd_end} = {c, s[11:8], s, e};
    {cmd_data, cmd_sec} = {d, d[2:0]};
    n = 0;
    do @(posedge clk); while (!cmd_ready && ++n < 100);
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    while (!resp_valid && n < 20000) begin
      @(negedge clk);
      n++;
    end
    chk(resp_valid, 16'h1);
    chk(resp_ack, xa);
    chk(resp_data, xd);
  endtask

  task automatic wr(input logic [11:0] s, e, input logic ok,
    input logic [7:0] d0);
    logic [7:0] d;
    logic m;
    cmd(4'h3, s, e, 8'h00, ok, 16'h0000);
    for (int a = s; ok && a <= e; a++) begin
      step();
      d = (s == e) ? d0 : x[7:0];
      m = (mem_r[a] & d) == d;
      cmd(4'h4, 12'h000, 12'h000, d, m, 16'h0000);
      mem_r[a] = mem_r[a] & d;
      if (!m) break;
    end
  endtask

  task automatic ent();
    @(negedge clk);
    prog_conn_pin = 1'b0;
    repeat (4) @(negedge clk);
    chk(prog_mode, 16'h0);
    prog_conn_pin = 1'b1;
    repeat (4) @(negedge clk);
    cmd(4'h0, 12'h000, 12'h000, 8'h00, 1'b1, 16'h0000);
    chk(prog_mode, 16'h1);
    act = st;
  endtask

  task automatic sp(input logic er, input logic [11:0] a,
    input logic [7:0] d);
    int n;
    @(negedge clk);
    sp_valid = 1'b1;
    {sp_erase, sp_block, sp_addr, sp_data} = {er, a[11:8], a, d};
    n = 0;
    do @(posedge clk); while (!sp_ready && ++n < 100);
    @(negedge clk);
    sp_valid = 1'b0;
    n = 0;
    while (!sp_done && n < 20000) begin
      @(negedge clk);
      n++;
    end
    chk(sp_done, 16'h1);
    chk(sp_ok, er | ((mem_r[a] & d) == d));
    if (er) ers({1'b0, a[11:8]});
    else mem_r[a] = mem_r[a] & d;
  endtask

  // ==========================================================================
  // Clock and timeout
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fails++;
      results();
    end
  end

  // ==========================================================================
  // Scenarios
  initial begin
    logic [11:0] s, e, a;
    logic [7:0] d;
    logic [2:0] tab [4];
    tab = '{3'h2, 3'h4, 3'h6, 3'h1};
    {arst_n, prog_conn_pin, cmd_valid, sp_valid, sp_erase} = '0;
    {cmd_code, cmd_block, cmd_start, cmd_end, cmd_data, cmd_sec} = '0;
    {sp_block, sp_addr, sp_data} = '0;
    x = 32'h20;
    for (int i = 0; i < 4096; i++) mem_r[i] = 8'h00;
    {st, act} = '0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    chk(sec_active, 16'h0);
    cmd(4'h1, 12'h000, 12'hfff, 8'h00, 1'b0, 16'h0000);
    cmd(4'h0, 12'h000, 12'h000, 8'h00, 1'b0, 16'h0000);
    ent();
    cmd(4'h6, 12'h000, 12'hfff, 8'h00, 1'b1, 16'h0000);
    cmd(4'h1, 12'h000, 12'hfff, 8'h00, 1'b1, 16'h0000);
    ers(5'h10);
    cmd(4'h6, 12'h000, 12'hfff, 8'h00, 1'b1, 16'h0001);
    step();
    s = x[11:0];
    e = s | 12'h00f;
    wr(s, e, 1'b1, 8'h00);
    cmd(4'h4, 12'h000, 12'h000, 8'h5a, 1'b0, 16'h0000);
    cmd(4'h5, s, e, 8'h00, 1'b1, cks(s, e));
    cmd(4'h6, 12'h000, 12'hfff, 8'h00, 1'b1, {15'h0, blank()});
    cmd(4'h2, s, s, 8'h00, 1'b1, 16'h0000);
    ers({1'b0, s[11:8]});
    cmd(4'h5, 12'h000, 12'hfff, 8'h00, 1'b1, cks(12'h000, 12'hfff));
    for (int i = 8; i < 16; i++) begin
      cmd(i[3:0], s, e, 8'h00, 1'b0, 16'h0000);
    end
    cmd(4'h3, 12'h011, 12'h010, 8'h00, 1'b0, 16'h0000);
    foreach (tab[i]) begin
      step();
      a = x[11:0];
      d = x[19:12] & 8'h7f | 8'h01;
      cmd(4'h7, a, a, {5'h0, tab[i]}, 1'b1, 16'h0000);
      st = st | tab[i];
      cmd(4'h0, 12'h000, 12'h000, 8'h00, 1'b1, 16'h0000);
      cmd(4'h2, a, a, 8'h00, act == 3'h0, 16'h0000);
      if (act == 3'h0) ers({1'b0, a[11:8]});
      chk(sec_active, act);
      ent();
      chk(sec_active, act);
      cmd(4'h2, a, a, 8'h00, 1'b0, 16'h0000);
      wr(a, a, !act[2], d);
      wr(a, a, !act[2], ~d);
      s = {a[11:8], 8'h00};
      e = {a[11:8], 8'hff};
      cmd(4'h5, s, e, 8'h00, 1'b1, cks(s, e));
      cmd(4'h1, a, a, 8'h00, !act[0], 16'h0000);
      if (!act[0]) begin
        ers(5'h10);
        st = 3'h0;
      end
      ent();
      chk(sec_active, st);
    end
    @(negedge clk);
    prog_conn_pin = 1'b0;
    repeat (4) @(negedge clk);
    sp(1'b1, a, 8'h00);
    sp(1'b0, a, d);
    ent();
    chk(sec_active, 16'h1);
    cmd(4'h5, s, e, 8'h00, 1'b1, cks(s, e));
    results();
  end
endmodule

`default_nettype wire
